/* rtl/queue_pkg.sv */
// Functional notes
// - one 64-byte queue, both directions
// - host write stores byte, advances write pointer
// - host read returns byte, advances read pointer
// - seven-bit fill count is pointer distance
// - engine shares queue; host avoids stray accesses
// - host access limited per active command
// - send-then-receive: host tracks current direction
// - nvm read: arguments written, then only reads
// - purge resets pointers, count, overrun flag
// - near full when 64 minus count <= threshold
// - near empty when count <= threshold
// - overrun flag readable with irq and alerts
// - interrupt on near-empty request and flag
// - interrupt on near-full request and flag
// - threshold resets to eight
// - request drives interrupt only when enabled
`default_nettype none
package queue_pkg;
	// ==========================================
	// queue geometry
	localparam int DEPTH = 64;
	localparam logic [6:0] FILL_MAX = 7'h40;
	// ==========================================
	// device register port map
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_FILL = 3'h1;
	localparam logic [2:0] REG_STAT = 3'h2;
	localparam logic [2:0] REG_CTRL = 3'h3;
	localparam logic [2:0] REG_THR = 3'h4;
	localparam logic [2:0] REG_IEN = 3'h5;
	localparam logic [2:0] REG_IREQ = 3'h6;
	localparam int ST_NEAR_EMPTY = 0;
	localparam int ST_NEAR_FULL = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_IRQ = 3;
	localparam int CTRL_PURGE = 0;
	localparam logic [5:0] THR_RESET = 6'h08;
	// ==========================================
	// host controller register map (word index)
	localparam logic [2:0] HR_CMD = 3'h0;
	localparam logic [2:0] HR_ADDR = 3'h1;
	localparam logic [2:0] HR_WDATA = 3'h2;
	localparam logic [2:0] HR_GO = 3'h3;
	localparam logic [2:0] HR_RESULT = 3'h4;
	localparam logic [2:0] HR_STAT = 3'h5;
	localparam logic [2:0] HR_MASK = 3'h6;
	localparam int CMD_PHASE = 4;
	localparam int GO_READ = 0;
	localparam int HS_BUSY = 0;
	localparam int HS_DONE = 1;
	localparam int HS_REFUSED = 2;
	localparam int HS_DEVIRQ = 3;
	// ==========================================
	// active command codes
	localparam logic [3:0] CMD_STARTUP = 4'h0;
	localparam logic [3:0] CMD_IDLE = 4'h1;
	localparam logic [3:0] CMD_TRANSMIT = 4'h2;
	localparam logic [3:0] CMD_RECEIVE = 4'h3;
	localparam logic [3:0] CMD_TRANSCEIVE = 4'h4;
	localparam logic [3:0] CMD_NVM_WRITE = 4'h5;
	localparam logic [3:0] CMD_NVM_READ = 4'h6;
	localparam logic [3:0] CMD_KEY_NVM = 4'h7;
	localparam logic [3:0] CMD_KEY_QUEUE = 4'h8;
	localparam logic [3:0] CMD_AUTH_ONE = 4'h9;
	localparam logic [3:0] CMD_AUTH_TWO = 4'hA;
	localparam logic [3:0] CMD_CONFIG_LOAD = 4'hB;
	localparam logic [3:0] CMD_CHECKSUM = 4'hC;
	// ==========================================
	// host link sequencer
	typedef enum logic [1:0] {
		LK_IDLE = 2'b01,
		LK_WAIT = 2'b10
	} link_state_t;
endpackage
`default_nettype wire

/* rtl/queue_if.sv */
`default_nettype none
// register port between host controller and queue device
interface queue_if;
	logic req;
	logic wr;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	logic irq;
	modport dev_mp (input req, input wr, input addr, input wdata,
		output ack, output rdata, output irq);
	modport host_mp (output req, output wr, output addr, output wdata,
		input ack, input rdata, input irq);
endinterface
`default_nettype wire

/* rtl/queue_device.sv */
`default_nettype none
module queue_device (
	input wire logic clk,
	input wire logic srst,
	queue_if.dev_mp bus,
	input wire logic eng_push,
	input wire logic [7:0] eng_push_data,
	input wire logic eng_pop,
	output logic [7:0] eng_pop_data,
	output logic [6:0] eng_fill,
	output logic eng_full,
	output logic eng_empty
);
	// ==========================================
	// storage and state
	logic [7:0] mem [queue_pkg::DEPTH];
	logic [5:0] wptr_ff;
	logic [5:0] rptr_ff;
	logic [6:0] fill_ff;
	logic overrun_ff;
	logic [5:0] thr_ff;
	logic [1:0] ien_ff;
	logic [1:0] ireq_ff;
	logic irq_ff;
	logic ack_ff;
	logic [7:0] rdata_ff;
	logic [7:0] eng_pop_data_ff;
	logic eng_full_ff;
	logic eng_empty_ff;
	logic [6:0] nxt_fill;
	logic [1:0] nxt_ireq;
	logic [7:0] rd_mux;

	// ==========================================
	// access decode
	wire host_wr = bus.req & bus.wr;
	wire host_rd = bus.req & ~bus.wr;
	wire q_wr_host = host_wr & (bus.addr == queue_pkg::REG_DATA);
	wire q_rd_host = host_rd & (bus.addr == queue_pkg::REG_DATA);
	wire purge = host_wr & (bus.addr == queue_pkg::REG_CTRL)
		& bus.wdata[queue_pkg::CTRL_PURGE];
	wire thr_wr = host_wr & (bus.addr == queue_pkg::REG_THR);
	wire ien_wr = host_wr & (bus.addr == queue_pkg::REG_IEN);
	wire ireq_wr = host_wr & (bus.addr == queue_pkg::REG_IREQ);

	// host port wins over the engine in the same cycle
	wire push_req = q_wr_host | eng_push;
	wire [7:0] push_data = q_wr_host ? bus.wdata : eng_push_data;
	wire pop_req = q_rd_host | eng_pop;
	wire eng_pop_taken = eng_pop & ~q_rd_host;
	wire full = (fill_ff == queue_pkg::FILL_MAX);
	wire empty = (fill_ff == 7'h00);
	wire do_push = push_req & ~full & ~purge;
	wire do_pop = pop_req & ~empty & ~purge;
	wire overrun_evt = push_req & full & ~purge;

	// ==========================================
	// alert flags
	wire [6:0] free_cnt = queue_pkg::FILL_MAX - fill_ff;
	wire near_full = (free_cnt <= {1'b0, thr_ff});
	wire near_empty = (fill_ff <= {1'b0, thr_ff});
	wire [1:0] alert = {near_full, near_empty};
	wire [1:0] ireq_clr = ireq_wr ? bus.wdata[1:0] : 2'h0;

	// fill count follows pointer movement
	always_comb begin
		if (purge) begin
			nxt_fill = 7'h00;
		end else if (do_push && !do_pop) begin
			nxt_fill = fill_ff + 7'h01;
		end else if (do_pop && !do_push) begin
			nxt_fill = fill_ff - 7'h01;
		end else begin
			nxt_fill = fill_ff;
		end
	end

	// sticky requests; a raised flag beats a clear
	always_comb begin
		nxt_ireq = (ireq_ff & ~ireq_clr) | alert;
	end

	// register read selection
	always_comb begin
		case (bus.addr)
			queue_pkg::REG_DATA: rd_mux = mem[rptr_ff];
			queue_pkg::REG_FILL: rd_mux = {1'b0, fill_ff};
			queue_pkg::REG_STAT: rd_mux = {4'h0, irq_ff, overrun_ff,
				near_full, near_empty};
			queue_pkg::REG_CTRL: rd_mux = 8'h00;
			queue_pkg::REG_THR: rd_mux = {2'h0, thr_ff};
			queue_pkg::REG_IEN: rd_mux = {6'h00, ien_ff};
			queue_pkg::REG_IREQ: rd_mux = {6'h00, ireq_ff};
			default: rd_mux = 8'h00;
		endcase
	end

	// ==========================================
	// queue storage write
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wptr_ff] <= push_data;
		end
	end

	// pointers, count and overrun
	always_ff @(posedge clk) begin
		if (srst || purge) begin
			wptr_ff <= 6'h00;
			rptr_ff <= 6'h00;
			overrun_ff <= 1'b0;
		end else begin
			if (do_push) begin
				wptr_ff <= wptr_ff + 6'h01;
			end
			if (do_pop) begin
				rptr_ff <= rptr_ff + 6'h01;
			end
			if (overrun_evt) begin
				overrun_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			fill_ff <= 7'h00;
		end else begin
			fill_ff <= nxt_fill;
		end
	end

	// configuration and interrupt registers
	always_ff @(posedge clk) begin
		if (srst) begin
			thr_ff <= queue_pkg::THR_RESET;
			ien_ff <= 2'h0;
			ireq_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			if (thr_wr) begin
				thr_ff <= bus.wdata[5:0];
			end
			if (ien_wr) begin
				ien_ff <= bus.wdata[1:0];
			end
			ireq_ff <= nxt_ireq;
			irq_ff <= |(ireq_ff & ien_ff);
		end
	end

	// register port answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			ack_ff <= bus.req;
			if (host_rd) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// engine side outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			eng_pop_data_ff <= 8'h00;
			eng_full_ff <= 1'b0;
			eng_empty_ff <= 1'b1;
		end else begin
			if (eng_pop_taken && !empty) begin
				eng_pop_data_ff <= mem[rptr_ff];
			end
			eng_full_ff <= (nxt_fill == queue_pkg::FILL_MAX);
			eng_empty_ff <= (nxt_fill == 7'h00);
		end
	end

	// ==========================================
	// outputs
	assign bus.ack = ack_ff;
	assign bus.rdata = rdata_ff;
	assign bus.irq = irq_ff;
	assign eng_pop_data = eng_pop_data_ff;
	assign eng_fill = fill_ff;
	assign eng_full = eng_full_ff;
	assign eng_empty = eng_empty_ff;
endmodule // queue_device
`default_nettype wire

/* rtl/queue_host.sv */
`default_nettype none
module queue_host (
	input wire logic clk,
	input wire logic srst,
	queue_if.host_mp bus,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq
);
	// ==========================================
	// state
	queue_pkg::link_state_t state_ff;
	logic wait_ff;
	logic [31:0] readdata_ff;
	logic [3:0] cmd_ff;
	logic phase_ff;
	logic args_done_ff;
	logic [2:0] laddr_ff;
	logic [7:0] lwdata_ff;
	logic [7:0] result_ff;
	logic [3:1] sticky_ff;
	logic [3:1] mask_ff;
	logic irq_ff;
	logic req_ff;
	logic wr_ff;
	logic [2:0] addr_ff;
	logic [7:0] wdata_ff;
	logic [31:0] rd_mux;

	// ==========================================
	// bus decode
	wire acc = (avs_read | avs_write) & wait_ff;
	wire wr_acc = acc & avs_write;
	wire rd_acc = acc & avs_read;
	wire idle = (state_ff == queue_pkg::LK_IDLE);
	wire go = wr_acc & (avs_address == queue_pkg::HR_GO);
	wire go_rd = avs_writedata[queue_pkg::GO_READ];
	wire is_queue = (laddr_ff == queue_pkg::REG_DATA);

	// per-command queue permissions
	wire tx_cmd = (cmd_ff == queue_pkg::CMD_TRANSMIT)
		| (cmd_ff == queue_pkg::CMD_NVM_WRITE)
		| (cmd_ff == queue_pkg::CMD_KEY_NVM)
		| (cmd_ff == queue_pkg::CMD_KEY_QUEUE)
		| (cmd_ff == queue_pkg::CMD_AUTH_ONE)
		| (cmd_ff == queue_pkg::CMD_CONFIG_LOAD)
		| (cmd_ff == queue_pkg::CMD_CHECKSUM);
	wire xcv = (cmd_ff == queue_pkg::CMD_TRANSCEIVE);
	wire nvm_rd = (cmd_ff == queue_pkg::CMD_NVM_READ);
	wire may_wr = tx_cmd | (xcv & ~phase_ff)
		| (nvm_rd & ~args_done_ff);
	wire may_rd = (cmd_ff == queue_pkg::CMD_RECEIVE)
		| (xcv & phase_ff) | nvm_rd;
	wire allowed = ~is_queue | (go_rd ? may_rd : may_wr);
	wire launch = go & idle & allowed;
	wire refuse = go & idle & ~allowed;
	wire done = ~idle & bus.ack;
	wire [3:1] events = {bus.irq, refuse, done};
	wire [3:1] st_clr = (rd_acc && avs_address == queue_pkg::HR_STAT)
		? 3'h7 : 3'h0;

	// register read selection
	always_comb begin
		case (avs_address)
			queue_pkg::HR_CMD: rd_mux = {27'h0, phase_ff, cmd_ff};
			queue_pkg::HR_ADDR: rd_mux = {29'h0, laddr_ff};
			queue_pkg::HR_WDATA: rd_mux = {24'h0, lwdata_ff};
			queue_pkg::HR_RESULT: rd_mux = {24'h0, result_ff};
			queue_pkg::HR_STAT: rd_mux = {28'h0, sticky_ff, ~idle};
			queue_pkg::HR_MASK: rd_mux = {28'h0, mask_ff, 1'b0};
			default: rd_mux = 32'h0;
		endcase
	end

	// ==========================================
	// avalon slave: one low waitrequest cycle per access
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_ff <= 1'b1;
			readdata_ff <= 32'h0;
		end else begin
			wait_ff <= ~acc;
			if (rd_acc) begin
				readdata_ff <= rd_mux;
			end
		end
	end

	// software registers
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_ff <= queue_pkg::CMD_STARTUP;
			phase_ff <= 1'b0;
			laddr_ff <= 3'h0;
			lwdata_ff <= 8'h00;
			mask_ff <= 3'h0;
		end else if (wr_acc) begin
			case (avs_address)
				queue_pkg::HR_CMD: begin
					cmd_ff <= avs_writedata[3:0];
					phase_ff <= avs_writedata[queue_pkg::CMD_PHASE];
				end
				queue_pkg::HR_ADDR: laddr_ff <= avs_writedata[2:0];
				queue_pkg::HR_WDATA: lwdata_ff <= avs_writedata[7:0];
				queue_pkg::HR_MASK: mask_ff <= avs_writedata[3:1];
				default: ;
			endcase
		end
	end

	// argument phase of nvm read ends at first queue read
	always_ff @(posedge clk) begin
		if (srst || (wr_acc && avs_address == queue_pkg::HR_CMD)) begin
			args_done_ff <= 1'b0;
		end else if (launch && is_queue && go_rd) begin
			args_done_ff <= 1'b1;
		end
	end

	// sticky status, read clears, event wins; masked level irq
	always_ff @(posedge clk) begin
		if (srst) begin
			sticky_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			sticky_ff <= (sticky_ff & ~st_clr) | events;
			irq_ff <= |(sticky_ff & mask_ff);
		end
	end

	// link sequencer: one request, wait for the answer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= queue_pkg::LK_IDLE;
			req_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= 3'h0;
			wdata_ff <= 8'h00;
			result_ff <= 8'h00;
		end else begin
			req_ff <= 1'b0;
			case (state_ff)
				queue_pkg::LK_IDLE: begin
					if (launch) begin
						req_ff <= 1'b1;
						wr_ff <= ~go_rd;
						addr_ff <= laddr_ff;
						wdata_ff <= lwdata_ff;
						state_ff <= queue_pkg::LK_WAIT;
					end
				end
				queue_pkg::LK_WAIT: begin
					if (bus.ack) begin
						if (!wr_ff) begin
							result_ff <= bus.rdata;
						end
						state_ff <= queue_pkg::LK_IDLE;
					end
				end
				default: state_ff <= queue_pkg::LK_IDLE;
			endcase
		end
	end

	// ==========================================
	// outputs
	assign avs_readdata = readdata_ff;
	assign avs_waitrequest = wait_ff;
	assign irq = irq_ff;
	assign bus.req = req_ff;
	assign bus.wr = wr_ff;
	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
endmodule // queue_host
`default_nettype wire

/* tb/queue_checker.sv */
`default_nettype none
module queue_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic req,
	input wire logic wr,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic eng_push,
	input wire logic [7:0] eng_push_data,
	input wire logic eng_pop
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic [7:0] mem_ff [64];
	logic [5:0] wp_ff;
	logic [5:0] rp_ff;
	logic [6:0] cnt_ff;
	logic [5:0] thr_ff;
	logic [1:0] ien_ff;
	logic ovr_ff;
	// ==========
	// link request decode
	wire logic rq = req && !wr;
	wire logic wq = req && wr;
	wire logic full = cnt_ff == queue_pkg::FILL_MAX;
	// host port and engine share the queue; host wins a shared cycle
	wire logic hput = wq && addr == queue_pkg::REG_DATA;
	wire logic hget = rq && addr == queue_pkg::REG_DATA;
	wire logic put = (hput || eng_push) && !full;
	wire logic lost = (hput || eng_push) && full;
	wire logic get = (hget || eng_pop) && cnt_ff != 7'h00;
	wire logic [7:0] pdata = hput ? wdata : eng_push_data;
	wire logic purge = wq && addr == queue_pkg::REG_CTRL && wdata[0];
	wire logic r_stat = rq && addr == queue_pkg::REG_STAT;
	wire logic ne = cnt_ff <= {1'b0, thr_ff};
	wire logic nf = queue_pkg::FILL_MAX - cnt_ff <= {1'b0, thr_ff};
	wire logic [7:0] head = mem_ff[rp_ff];
	// shadow of stored bytes
	always_ff @(posedge clk) begin
		if (put) begin
			mem_ff[wp_ff] <= pdata;
		end
	end
	// shadow pointers and overrun
	always_ff @(posedge clk) begin
		if (srst || purge) begin
			wp_ff <= 6'h00;
			rp_ff <= 6'h00;
			cnt_ff <= 7'h00;
			ovr_ff <= 1'b0;
		end else begin
			wp_ff <= wp_ff + 6'(put);
			rp_ff <= rp_ff + 6'(get);
			cnt_ff <= cnt_ff + 7'(put) - 7'(get);
			ovr_ff <= ovr_ff | lost;
		end
	end
	// shadow threshold and enables
	always_ff @(posedge clk) begin
		if (srst) begin
			thr_ff <= queue_pkg::THR_RESET;
			ien_ff <= 2'h0;
		end else begin
			thr_ff <= (wq && addr == queue_pkg::REG_THR) ? wdata[5:0] : thr_ff;
			ien_ff <= (wq && addr == queue_pkg::REG_IEN) ? wdata[1:0] : ien_ff;
		end
	end
	// ==========
	// properties
	a_ack_next: assert property (req |=> ack)
		else $error("no ack after request");
	a_ack_single: assert property (ack |=> !ack)
		else $error("ack too long");
	a_fill_count: assert property (rq && addr == queue_pkg::REG_FILL |=>
		rdata == {1'b0, cnt_ff})
		else $error("fill count wrong");
	a_data_order: assert property (get && hget |=> rdata == $past(head))
		else $error("byte out of order");
	a_near_full: assert property (r_stat |=> rdata[1] == nf)
		else $error("near full wrong");
	a_near_empty: assert property (r_stat |=> rdata[0] == ne)
		else $error("near empty wrong");
	a_overrun_flag: assert property (r_stat |=> rdata[2] == ovr_ff)
		else $error("overrun wrong");
	a_thr_value: assert property (rq && addr == queue_pkg::REG_THR |=> rdata[5:0] == thr_ff)
		else $error("threshold wrong");
	a_irq_gated: assert property (ien_ff == 2'h0 [*3] |-> !irq)
		else $error("irq while disabled");
	a_irq_empty: assert property ((ien_ff[0] && ne) [*3] |-> irq)
		else $error("no near empty irq");
	a_irq_full: assert property ((ien_ff[1] && nf) [*3] |-> irq)
		else $error("no near full irq");
endmodule // queue_checker
`default_nettype wire

/* tb/tb_shared_byte_fifo_with_alerts.sv */
`default_nettype none
module tb_shared_byte_fifo_with_alerts;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic srst;
	logic [2:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic eng_push;
	logic [7:0] eng_push_data;
	logic eng_pop;
	logic [7:0] eng_pop_data;
	logic [6:0] eng_fill;
	logic eng_full;
	logic eng_empty;
	int err_total;
	int tests_run;
	logic [32:0] exp_q[$];
	logic [32:0] note;
	logic [7:0] mdl_q[$];
	logic [31:0] rd;
	logic [7:0] b;
	logic [5:0] thr;
	logic [12:0] wr_ok = 13'h1BF4;
	queue_if link();
	queue_device u_queue_device (.clk(clk), .srst(srst), .bus(link),
		.eng_push(eng_push), .eng_push_data(eng_push_data), .eng_pop(eng_pop),
		.eng_pop_data(eng_pop_data), .eng_fill(eng_fill), .eng_full(eng_full),
		.eng_empty(eng_empty));
	queue_host u_queue_host (.clk(clk), .srst(srst), .bus(link),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq));
	queue_checker u_queue_checker (.clk(clk), .srst(srst), .req(link.req), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
		.irq(link.irq), .eng_push(eng_push), .eng_push_data(eng_push_data),
		.eng_pop(eng_pop));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========
	// tasks
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one avalon transfer held until waitrequest is sampled low
	task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
			if (n > 40) begin
				err_total++;
				end_sim();
			end
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic hr(input logic [2:0] a, input logic c, input logic [31:0] e);
		exp_q.push_back({c, e});
		av(1'b0, a, 32'h0);
	endtask
	// link operation, then poll until done or refused
	task automatic dop(input logic w, input logic [2:0] a, input logic [7:0] d);
		av(1'b1, queue_pkg::HR_ADDR, 32'(a));
		av(1'b1, queue_pkg::HR_WDATA, 32'(d));
		av(1'b1, queue_pkg::HR_GO, 32'(!w));
		repeat (20) begin
			hr(queue_pkg::HR_STAT, 1'b0, 32'h0);
			if (rd[queue_pkg::HS_DONE] === 1'b1 || rd[queue_pkg::HS_REFUSED] === 1'b1) begin
				return;
			end
		end
		err_total++;
		end_sim();
	endtask
	task automatic dchk(input logic [2:0] a, input logic [7:0] e);
		dop(1'b0, a, 8'h00);
		hr(queue_pkg::HR_RESULT, 1'b1, 32'(e));
	endtask
	task automatic wirq(input logic e);
		for (int i = 0; i < 10 && irq !== e; i++) begin
			@(posedge clk);
		end
		chk("irq", 32'(e), 32'(irq));
	endtask
	// watcher pairs each finished read with the oldest note
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			note = exp_q.pop_front();
			if (note[32]) begin
				chk("readdata", note[31:0], avs_readdata);
			end
		end
	end
	// ==========
	// main sequence
	initial begin
		err_total = 0;
		tests_run = 0;
		srst = 1'b1;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		eng_push = 1'b0;
		eng_push_data = 8'h00;
		eng_pop = 1'b0;
		rd = $urandom(69);
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		dchk(queue_pkg::REG_THR, 8'h08);
		dchk(queue_pkg::REG_FILL, 8'h00);
		dchk(3'h7, 8'h00);
		hr(3'h7, 1'b0, 32'h0);
		$display("test reset done");
		// fill to the brim, alerts at every count
		thr = 6'($urandom_range(62, 1));
		dop(1'b1, queue_pkg::REG_THR, {2'b00, thr});
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_TRANSMIT));
		for (int i = 1; i <= 64; i++) begin
			b = 8'($urandom);
			mdl_q.push_back(b);
			dop(1'b1, queue_pkg::REG_DATA, b);
			dchk(queue_pkg::REG_STAT, {6'h00, 7'(64 - i) <= {1'b0, thr},
				7'(i) <= {1'b0, thr}});
		end
		dop(1'b1, queue_pkg::REG_DATA, 8'h5A);
		dchk(queue_pkg::REG_FILL, 8'h40);
		dchk(queue_pkg::REG_STAT, 8'h06);
		chk("eng_full", 32'h1, 32'(eng_full));
		dop(1'b0, queue_pkg::REG_DATA, 8'h00);
		chk("refused", 32'h1, 32'(rd[queue_pkg::HS_REFUSED]));
		$display("test fill done");
		// drain in order
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_RECEIVE));
		while (mdl_q.size() > 0) begin
			dchk(queue_pkg::REG_DATA, mdl_q.pop_front());
		end
		dchk(queue_pkg::REG_FILL, 8'h00);
		// every command against the write permissions
		for (int c = 0; c <= 12; c++) begin
			av(1'b1, queue_pkg::HR_CMD, 32'(c));
			dop(1'b1, queue_pkg::REG_DATA, 8'(c));
			chk("refused", 32'(!wr_ok[c]), 32'(rd[queue_pkg::HS_REFUSED]));
		end
		dchk(queue_pkg::REG_FILL, 8'h09);
		av(1'b1, queue_pkg::HR_CMD, 32'h14);
		hr(queue_pkg::HR_CMD, 1'b1, 32'h14);
		dchk(queue_pkg::REG_DATA, 8'h02);
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_NVM_READ));
		dchk(queue_pkg::REG_DATA, 8'h04);
		dop(1'b1, queue_pkg::REG_DATA, 8'h77);
		chk("refused", 32'h1, 32'(rd[queue_pkg::HS_REFUSED]));
		dop(1'b1, queue_pkg::REG_CTRL, 8'h01);
		dchk(queue_pkg::REG_FILL, 8'h00);
		dchk(queue_pkg::REG_STAT, 8'h01);
		$display("test commands done");
		// alerts raise, mask and clear the interrupt
		dop(1'b1, queue_pkg::REG_THR, 8'h3F);
		av(1'b1, queue_pkg::HR_MASK, 32'h8);
		hr(queue_pkg::HR_MASK, 1'b1, 32'h8);
		dop(1'b1, queue_pkg::REG_IREQ, 8'h03);
		dchk(queue_pkg::REG_IREQ, 8'h01);
		dop(1'b1, queue_pkg::REG_IEN, 8'h02);
		dchk(queue_pkg::REG_STAT, 8'h01);
		dop(1'b1, queue_pkg::REG_IEN, 8'h01);
		dchk(queue_pkg::REG_IEN, 8'h01);
		dchk(queue_pkg::REG_STAT, 8'h09);
		wirq(1'b1);
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_TRANSMIT));
		dop(1'b1, queue_pkg::REG_DATA, 8'hC3);
		dop(1'b1, queue_pkg::REG_IEN, 8'h02);
		dchk(queue_pkg::REG_STAT, 8'h0B);
		dop(1'b1, queue_pkg::REG_IEN, 8'h00);
		dchk(queue_pkg::REG_STAT, 8'h03);
		hr(queue_pkg::HR_STAT, 1'b0, 32'h0);
		wirq(1'b0);
		$display("test irq done");
		// engine side shares the one queue with the host
		mdl_q.push_back(8'hC3);
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			mdl_q.push_back(b);
			@(posedge clk);
			eng_push <= 1'b1;
			eng_push_data <= b;
			@(posedge clk);
			eng_push <= 1'b0;
		end
		@(posedge clk);
		chk("eng_fill", 32'h4, 32'(eng_fill));
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_RECEIVE));
		while (mdl_q.size() > 0) begin
			dchk(queue_pkg::REG_DATA, mdl_q.pop_front());
		end
		chk("eng_empty", 32'h1, 32'(eng_empty));
		b = 8'($urandom);
		av(1'b1, queue_pkg::HR_CMD, 32'(queue_pkg::CMD_TRANSMIT));
		dop(1'b1, queue_pkg::REG_DATA, b);
		@(posedge clk);
		eng_pop <= 1'b1;
		@(posedge clk);
		eng_pop <= 1'b0;
		@(posedge clk);
		chk("eng_pop_data", 32'(b), 32'(eng_pop_data));
		chk("eng_empty", 32'h1, 32'(eng_empty));
		$display("test engine done");
		end_sim();
	end
endmodule // tb_shared_byte_fifo_with_alerts
`default_nettype wire
